// >>> core/trcd_top.sv
// Terminal run-command decoder with APB register slave
//
// Contract
// - Four step terminals form index, first is LSB
// - Full-scale step maps to maximum output frequency
// - Step value routable to loop or V/F
// - Two ramp terminals pick one of four sets
// - Code 41 terminal alone selects second motor set, code 42 the third
// - Every input debounced, 0 to 1000 ms
// - Two-bit scheme selects one of four run modes
// - Two-wire one: forward and reverse levels
// - Two-wire two: run level, direction level
// - Three-wire one: edges start while enable closed
// - Three-wire one: opening enable always stops
// - Three-wire one: edge starts, level enable
// - Three-wire two: edge runs, level sets direction
// - Three-wire two: opening enable stops
// - Functions assignable to any of ten inputs
// - Codes 41 and 42 select motor set
`timescale 1ns/100ps
module trcd_top
    import trcd_pkg::*;
#(
    parameter int TICK_CYC = DEB_TICK_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] term_in,
    output logic run_cmd,
    output logic dir_reverse,
    output logic start_pulse,
    output logic [3:0] step_index,
    output logic [1:0] ramp_set,
    output logic [1:0] motor_set,
    output logic [15:0] freq_ref,
    output logic [15:0] pid_setpoint,
    output logic [15:0] vf_voltage_ref
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // OR of the filtered inputs whose assigned function matches
    function automatic logic func_hit(input logic [9:0] lvl,
                                      input logic [5:0] codes [NUM_INPUTS],
                                      input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            hit = hit | (lvl[i] & (codes[i] == code));
        end
        return hit;
    endfunction : func_hit

    // Scale a step value, full scale mapping to the maximum frequency
    function automatic logic [15:0] scale_step(input logic [15:0] step,
                                               input logic [15:0] fmax);
        logic [15:0] clamped;
        logic [31:0] prod;
        clamped = (step > STEP_FULL_SCALE) ? STEP_FULL_SCALE : step;
        prod = clamped * fmax;
        return 16'(prod / 32'(STEP_FULL_SCALE));
    endfunction : scale_step

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] debounce_ff;
    trcd_scheme_t scheme_ff;
    logic [15:0] max_freq_ff;
    trcd_route_t route_ff;
    logic [15:0] step_val_ff [NUM_STEPS];
    logic [5:0] fcode_ff [NUM_INPUTS];
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [15:0] tick_cnt_ff;
    logic tick_ff;
    trcd_run_t state_ff;
    trcd_run_t nxt_state;
    logic fwd_q_ff;
    logic rev_q_ff;
    logic run_cmd_ff;
    logic dir_rev_ff;
    logic start_pulse_ff;
    logic [3:0] step_index_ff;
    logic [1:0] ramp_set_ff;
    logic [1:0] motor_set_ff;
    logic [15:0] freq_ref_ff;
    logic [15:0] pid_ff;
    logic [15:0] vf_ff;

    // ************************************************************
    // Input filter
    // ************************************************************
    trcd_deb_if dbus();

    assign dbus.raw = term_in;
    assign dbus.tick = tick_ff;
    assign dbus.time_ms = (debounce_ff > 16'(DEB_MAX_MS)) ? DEB_MAX_MS : debounce_ff[9:0];

    trcd_debounce i_trcd_debounce
    (
        .pclk(pclk),
        .presetn(presetn),
        .dbus(dbus)
    );

    // Millisecond tick shared by all ten filters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff == 16'(TICK_CYC - 1))
        begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    logic setup_ph;
    logic wr_en;
    logic [5:0] blk;
    logic [3:0] idx;
    logic hit_deb;
    logic hit_sch;
    logic hit_max;
    logic hit_route;
    logic hit_stat;
    logic hit_ref;
    logic hit_step;
    logic hit_fcode;
    logic mapped;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    // No wait state, answer in the first access cycle, one cycle after setup
    assign setup_ph = psel & ~penable;
    assign wr_en = psel & penable & pready_ff & pwrite;
    assign blk = paddr[11:6];
    assign idx = paddr[5:2];
    assign hit_deb = (paddr == OFS_DEBOUNCE);
    assign hit_sch = (paddr == OFS_SCHEME);
    assign hit_max = (paddr == OFS_MAX_FREQ);
    assign hit_route = (paddr == OFS_ROUTE);
    assign hit_stat = (paddr == OFS_STATUS);
    assign hit_ref = (paddr == OFS_REF_OUT);
    assign hit_step = (blk == BLK_STEP) & (paddr[1:0] == 2'h0);
    assign hit_fcode = (blk == BLK_FCODE) & (paddr[1:0] == 2'h0) & (idx < 4'hA);
    assign mapped = hit_deb | hit_sch | hit_max | hit_route | hit_stat | hit_ref |
                    hit_step | hit_fcode;

    assign status_word = (32'(run_cmd_ff) << ST_RUN_POS) |
                         (32'(dir_rev_ff) << ST_DIR_POS) |
                         (32'(step_index_ff) << ST_STEP_POS) |
                         (32'(ramp_set_ff) << ST_RAMP_POS) |
                         (32'(motor_set_ff) << ST_MOTOR_POS) |
                         (32'(dbus.filt) << ST_INPUT_POS);

    assign rd_mux = hit_deb ? {16'h0000, debounce_ff} :
                    hit_sch ? {30'h00000000, scheme_ff} :
                    hit_max ? {16'h0000, max_freq_ff} :
                    hit_route ? {30'h00000000, route_ff} :
                    hit_stat ? status_word :
                    hit_ref ? {16'h0000, freq_ref_ff} :
                    hit_step ? {16'h0000, step_val_ff[idx]} :
                    hit_fcode ? {26'h0000000, fcode_ff[idx]} :
                    32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= setup_ph;
            prdata_ff <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
            pslverr_ff <= setup_ph & ~mapped;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            debounce_ff <= RST_DEBOUNCE;
            scheme_ff <= trcd_scheme_t'(RST_SCHEME);
            max_freq_ff <= RST_MAX_FREQ;
            route_ff <= trcd_route_t'(RST_ROUTE);
            for (int i = 0; i < NUM_STEPS; i++)
            begin
                step_val_ff[i] <= 16'h0000;
            end
            for (int i = 0; i < NUM_INPUTS; i++)
            begin
                fcode_ff[i] <= 6'h00;
            end
            fcode_ff[0] <= FN_FORWARD;
            fcode_ff[1] <= FN_REVERSE;
            fcode_ff[2] <= FN_THREE_WIRE;
        end
        else if (wr_en)
        begin
            if (hit_deb)
            begin
                debounce_ff <= pwdata[15:0];
            end
            if (hit_sch)
            begin
                scheme_ff <= trcd_scheme_t'(pwdata[1:0]);
            end
            if (hit_max)
            begin
                max_freq_ff <= pwdata[15:0];
            end
            if (hit_route)
            begin
                route_ff <= trcd_route_t'(pwdata[1:0]);
            end
            if (hit_step)
            begin
                step_val_ff[idx] <= pwdata[15:0];
            end
            if (hit_fcode)
            begin
                fcode_ff[idx] <= pwdata[5:0];
            end
        end
    end

    // ************************************************************
    // Function decode on filtered levels
    // ************************************************************
    logic fwd_lvl;
    logic rev_lvl;
    logic en_lvl;
    logic fwd_rise;
    logic rev_rise;
    logic [3:0] nxt_step;
    logic [1:0] nxt_ramp;
    logic [1:0] nxt_motor;
    logic [15:0] sel_step;

    assign fwd_lvl = func_hit(dbus.filt, fcode_ff, FN_FORWARD);
    assign rev_lvl = func_hit(dbus.filt, fcode_ff, FN_REVERSE);
    assign en_lvl = func_hit(dbus.filt, fcode_ff, FN_THREE_WIRE);
    assign fwd_rise = fwd_lvl & ~fwd_q_ff;
    assign rev_rise = rev_lvl & ~rev_q_ff;
    assign nxt_step[0] = func_hit(dbus.filt, fcode_ff, FN_STEP_BIT0);
    assign nxt_step[1] = func_hit(dbus.filt, fcode_ff, FN_STEP_BIT0 + 6'h01);
    assign nxt_step[2] = func_hit(dbus.filt, fcode_ff, FN_STEP_BIT0 + 6'h02);
    assign nxt_step[3] = func_hit(dbus.filt, fcode_ff, FN_STEP_BIT0 + 6'h03);
    assign nxt_ramp[0] = func_hit(dbus.filt, fcode_ff, FN_RAMP_BIT0);
    assign nxt_ramp[1] = func_hit(dbus.filt, fcode_ff, FN_RAMP_BIT0 + 6'h01);
    assign nxt_motor[0] = func_hit(dbus.filt, fcode_ff, FN_MOTOR_BIT0);
    assign nxt_motor[1] = func_hit(dbus.filt, fcode_ff, FN_MOTOR_BIT1);
    assign sel_step = step_val_ff[nxt_step];

    // ************************************************************
    // Run-command state machine
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        case (scheme_ff)
            SCH_TWO_WIRE_1:
            begin
                // Both or neither held means stop
                if (fwd_lvl ^ rev_lvl)
                begin
                    nxt_state = fwd_lvl ? RUN_FWD : RUN_REV;
                end
                else
                begin
                    nxt_state = RUN_STOP;
                end
            end
            SCH_TWO_WIRE_2:
            begin
                if (fwd_lvl)
                begin
                    nxt_state = rev_lvl ? RUN_REV : RUN_FWD;
                end
                else
                begin
                    nxt_state = RUN_STOP;
                end
            end
            SCH_THREE_WIRE_1:
            begin
                // Enable is a level, starts are edges; forward wins a tie
                if (!en_lvl)
                begin
                    nxt_state = RUN_STOP;
                end
                else if (fwd_rise)
                begin
                    nxt_state = RUN_FWD;
                end
                else if (rev_rise)
                begin
                    nxt_state = RUN_REV;
                end
            end
            SCH_THREE_WIRE_2:
            begin
                if (!en_lvl)
                begin
                    nxt_state = RUN_STOP;
                end
                else if (fwd_rise || state_ff != RUN_STOP)
                begin
                    nxt_state = rev_lvl ? RUN_REV : RUN_FWD;
                end
            end
            default:
            begin
                nxt_state = RUN_STOP;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= RUN_STOP;
            fwd_q_ff <= 1'b0;
            rev_q_ff <= 1'b0;
            run_cmd_ff <= 1'b0;
            dir_rev_ff <= 1'b0;
            start_pulse_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            fwd_q_ff <= fwd_lvl;
            rev_q_ff <= rev_lvl;
            run_cmd_ff <= (nxt_state != RUN_STOP);
            dir_rev_ff <= (nxt_state == RUN_REV);
            start_pulse_ff <= (state_ff == RUN_STOP) && (nxt_state != RUN_STOP);
        end
    end

    // ************************************************************
    // Reference selection and scaling
    // ************************************************************
    // Unrouted outputs read zero so a consumer never acts on a stale step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_index_ff <= 4'h0;
            ramp_set_ff <= 2'h0;
            motor_set_ff <= 2'h0;
            freq_ref_ff <= 16'h0000;
            pid_ff <= 16'h0000;
            vf_ff <= 16'h0000;
        end
        else
        begin
            step_index_ff <= nxt_step;
            ramp_set_ff <= nxt_ramp;
            motor_set_ff <= nxt_motor;
            freq_ref_ff <= (route_ff == ROUTE_FREQ) ? scale_step(sel_step, max_freq_ff)
                                                    : 16'h0000;
            pid_ff <= (route_ff == ROUTE_PID) ? sel_step : 16'h0000;
            vf_ff <= (route_ff == ROUTE_VF) ? sel_step : 16'h0000;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign run_cmd = run_cmd_ff;
    assign dir_reverse = dir_rev_ff;
    assign start_pulse = start_pulse_ff;
    assign step_index = step_index_ff;
    assign ramp_set = ramp_set_ff;
    assign motor_set = motor_set_ff;
    assign freq_ref = freq_ref_ff;
    assign pid_setpoint = pid_ff;
    assign vf_voltage_ref = vf_ff;

endmodule : trcd_top

// >>> core/trcd_pkg.sv
// Package of constants and types for the terminal run-command decoder
package trcd_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int DEB_TICK_NS = 1000000;
    localparam int DEB_TICK_CYC = DEB_TICK_NS / CLK_PERIOD_NS;
    localparam logic [9:0] DEB_MAX_MS = 10'h3E8;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFS_DEBOUNCE = 12'h000;
    localparam logic [11:0] OFS_SCHEME = 12'h004;
    localparam logic [11:0] OFS_MAX_FREQ = 12'h008;
    localparam logic [11:0] OFS_ROUTE = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_REF_OUT = 12'h014;
    localparam logic [5:0] BLK_STEP = 6'h01;
    localparam logic [5:0] BLK_FCODE = 6'h02;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] RST_DEBOUNCE = 16'h000A;
    localparam logic [1:0] RST_SCHEME = 2'h0;
    localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
    localparam logic [1:0] RST_ROUTE = 2'h0;
    localparam logic [15:0] STEP_FULL_SCALE = 16'h03E8;

    // ************************************************************
    // Terminal function codes
    // ************************************************************
    localparam logic [5:0] FN_FORWARD = 6'h01;
    localparam logic [5:0] FN_REVERSE = 6'h02;
    localparam logic [5:0] FN_THREE_WIRE = 6'h03;
    localparam logic [5:0] FN_STEP_BIT0 = 6'h0C;
    localparam logic [5:0] FN_RAMP_BIT0 = 6'h10;
    localparam logic [5:0] FN_MOTOR_BIT0 = 6'h29;
    localparam logic [5:0] FN_MOTOR_BIT1 = 6'h2A;

    // ************************************************************
    // Status register field positions
    // ************************************************************
    localparam int ST_RUN_POS = 0;
    localparam int ST_DIR_POS = 1;
    localparam int ST_STEP_POS = 4;
    localparam int ST_RAMP_POS = 8;
    localparam int ST_MOTOR_POS = 10;
    localparam int ST_INPUT_POS = 16;

    localparam int NUM_INPUTS = 10;
    localparam int NUM_STEPS = 16;

    typedef enum logic [1:0]
    {
        SCH_TWO_WIRE_1 = 2'h0,
        SCH_TWO_WIRE_2 = 2'h1,
        SCH_THREE_WIRE_1 = 2'h2,
        SCH_THREE_WIRE_2 = 2'h3
    } trcd_scheme_t;

    typedef enum logic [1:0]
    {
        ROUTE_FREQ = 2'h0,
        ROUTE_PID = 2'h1,
        ROUTE_VF = 2'h2
    } trcd_route_t;

    // Gray order: stop, forward, reverse
    typedef enum logic [1:0]
    {
        RUN_STOP = 2'b00,
        RUN_FWD = 2'b01,
        RUN_REV = 2'b11
    } trcd_run_t;

endpackage : trcd_pkg

// >>> core/trcd_deb_if.sv
// Interface between the decoder core and its input filter
`timescale 1ns/100ps
interface trcd_deb_if;
    logic [9:0] raw;
    logic [9:0] filt;
    logic tick;
    logic [9:0] time_ms;

    modport deb
    (
        input raw,
        input tick,
        input time_ms,
        output filt
    );

    modport core
    (
        output raw,
        output tick,
        output time_ms,
        input filt
    );
endinterface : trcd_deb_if

// >>> core/trcd_debounce.sv
// Per-terminal debounce filter with millisecond filter time
`timescale 1ns/100ps
module trcd_debounce
    import trcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    trcd_deb_if.deb dbus
);

    logic [9:0] filt_ff;
    logic [9:0] cnt_ff [NUM_INPUTS];

    assign dbus.filt = filt_ff;

    // ************************************************************
    // A change must persist for the whole filter time to pass
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_ff <= 10'h000;
            for (int i = 0; i < NUM_INPUTS; i++)
            begin
                cnt_ff[i] <= 10'h000;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_INPUTS; i++)
            begin
                if (dbus.raw[i] == filt_ff[i])
                begin
                    cnt_ff[i] <= 10'h000;
                end
                else if (dbus.time_ms == 10'h000 ||
                         (dbus.tick && (cnt_ff[i] + 10'h001) >= dbus.time_ms))
                begin
                    filt_ff[i] <= dbus.raw[i];
                    cnt_ff[i] <= 10'h000;
                end
                else if (dbus.tick)
                begin
                    cnt_ff[i] <= cnt_ff[i] + 10'h001;
                end
            end
        end
    end

endmodule : trcd_debounce

// >>> verif/trcd_monitor.sv
// Port-level checker for the terminal run-command decoder
`timescale 1ns/100ps
module trcd_monitor
    import trcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic run_cmd,
    input wire logic dir_reverse,
    input wire logic start_pulse,
    input wire logic [15:0] freq_ref,
    input wire logic [15:0] pid_setpoint,
    input wire logic [15:0] vf_voltage_ref
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ************************************************************
    // Register bus
    // ************************************************************
    ready_after_setup_a: assert property (
        psel && !penable |=> pready) else $error("pready missing after setup");
    ready_cause_a: assert property (
        pready |-> $past(psel && !penable)) else $error("pready without setup");
    rdata_quiet_a: assert property (
        !(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
    misalign_err_a: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
        else $error("misaligned access not refused");
    // ************************************************************
    // Run command outputs
    // ************************************************************
    pulse_single_a: assert property (
        start_pulse |=> !start_pulse) else $error("start pulse too long");
    pulse_on_start_a: assert property (
        start_pulse |-> run_cmd && !$past(run_cmd)) else $error("start pulse without start");
    stop_dir_a: assert property (
        !run_cmd |-> !dir_reverse) else $error("direction set while stopped");
    route_excl_a: assert property (
        $onehot0({|freq_ref, |pid_setpoint, |vf_voltage_ref}))
        else $error("step value on two routes");
    cover property (start_pulse);
    cover property (pready && pslverr);
    cover property (run_cmd && dir_reverse);
endmodule : trcd_monitor

bind trcd_top trcd_monitor i_trcd_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_cmd(run_cmd), .dir_reverse(dir_reverse),
    .start_pulse(start_pulse), .freq_ref(freq_ref), .pid_setpoint(pid_setpoint),
    .vf_voltage_ref(vf_voltage_ref));

// >>> verif/trcd_switches.sv
// Behavioural model of the switches and push buttons on the terminals
`timescale 1ns/100ps
module trcd_switches
(
    input wire logic pclk,
    input wire logic [9:0] level,
    input wire logic chatter,
    output logic [9:0] term_in
);
    logic bounce_ff = 1'b0;
    // Contacts that chatter flip every cycle, never a clean level
    always @(posedge pclk) bounce_ff <= ~bounce_ff;
    assign term_in = chatter ? {10{bounce_ff}} : level;
endmodule : trcd_switches

// >>> verif/trcd_top_test.sv
// Self-checking testbench for the terminal run-command decoder
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module trcd_top_test;
    import trcd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, run_cmd, dir_reverse, start_pulse, chatter = 1'b0;
    logic [9:0] sw = 10'h000, term_in;
    logic [3:0] step_index;
    logic [1:0] ramp_set, motor_set;
    logic [15:0] freq_ref, pid_setpoint, vf_voltage_ref;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, n_start = 0;
    always #10 pclk = ~pclk;
    trcd_switches i_trcd_switches (.pclk(pclk), .level(sw), .chatter(chatter), .term_in(term_in));
    trcd_top #(.TICK_CYC(4)) i_trcd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in), .run_cmd(run_cmd),
        .dir_reverse(dir_reverse), .start_pulse(start_pulse), .step_index(step_index),
        .ramp_set(ramp_set), .motor_set(motor_set), .freq_ref(freq_ref),
        .pid_setpoint(pid_setpoint), .vf_voltage_ref(vf_voltage_ref));
    always @(posedge pclk)
    begin
        cyc++;
        if (start_pulse === 1'b1) n_start++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen at a rising edge; only the timeout ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic set_sw(input logic [9:0] v, input int wait_cyc);
        @(posedge pclk);
        sw <= v;
        repeat (wait_cyc) @(posedge pclk);
        @(negedge pclk);
    endtask : set_sw
    task automatic chk_run(input logic r, input logic d);
        `CHK("run_cmd", r, run_cmd)
        `CHK("dir_reverse", d, dir_reverse)
    endtask : chk_run
    task automatic test_regs();
        apb(1'b0, OFS_DEBOUNCE, 32'h0); `CHK("debounce", 32'h0000000A, rd)
        apb(1'b0, OFS_SCHEME, 32'h0); `CHK("scheme", 32'h0, rd)
        apb(1'b0, 12'h300, 32'h0); `CHK("unmapped err", 1'b1, err)
        apb(1'b0, 12'h042, 32'h0); `CHK("misaligned err", 1'b1, err)
        apb(1'b1, OFS_DEBOUNCE, 32'h0);
        for (int i = 3; i < 10; i++)
            apb(1'b1, 12'h080 + 12'(4 * i), 32'(i < 7 ? i + 9 : (i < 9 ? i + 9 : 8'h29)));
        for (int i = 0; i < 16; i++) apb(1'b1, 12'h040 + 12'(4 * i), 32'(i * 67));
    endtask : test_regs
    task automatic test_two_wire();
        logic [1:0] t;
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, OFS_SCHEME, 32'(m));
            for (int k = 0; k < 4; k++)
            begin
                t = 2'(k);
                set_sw({8'h00, t}, 6);
                if (m == 0) chk_run(^t, t == 2'b10);
                else chk_run(t[0], t == 2'b11);
            end
        end
    endtask : test_two_wire
    task automatic test_three_wire_one();
        apb(1'b1, OFS_SCHEME, 32'h2);
        set_sw(10'h001, 6); chk_run(1'b0, 1'b0);
        set_sw(10'h004, 6); chk_run(1'b0, 1'b0);
        n_start = 0;
        set_sw(10'h005, 6); chk_run(1'b1, 1'b0);
        `CHK("one start pulse", 1, n_start)
        set_sw(10'h004, 6); chk_run(1'b1, 1'b0);
        set_sw(10'h005, 6);
        set_sw(10'h001, 6); chk_run(1'b0, 1'b0);
        set_sw(10'h005, 6); chk_run(1'b0, 1'b0);
        set_sw(10'h007, 6); chk_run(1'b1, 1'b1);
    endtask : test_three_wire_one
    task automatic test_three_wire_two();
        apb(1'b1, OFS_SCHEME, 32'h3);
        set_sw(10'h000, 6);
        set_sw(10'h006, 6); chk_run(1'b0, 1'b0);
        set_sw(10'h007, 6); chk_run(1'b1, 1'b1);
        set_sw(10'h005, 6); chk_run(1'b1, 1'b0);
        set_sw(10'h001, 6); chk_run(1'b0, 1'b0);
    endtask : test_three_wire_two
    task automatic test_steps();
        int s;
        for (int i = 0; i < 16; i++)
        begin
            s = i * 67;
            set_sw(10'(i << 3), 6);
            `CHK("step_index", 4'(i), step_index)
            `CHK("freq_ref", 16'((s > 1000 ? 1000 : s) * 5), freq_ref)
        end
        apb(1'b1, OFS_ROUTE, 32'h1); repeat (3) @(posedge pclk);
        `CHK("pid_setpoint", 16'h03ED, pid_setpoint)
        apb(1'b1, OFS_ROUTE, 32'h2); repeat (3) @(posedge pclk);
        `CHK("vf_voltage_ref", 16'h03ED, vf_voltage_ref)
    endtask : test_steps
    task automatic test_ramp_motor();
        for (int k = 0; k < 4; k++)
        begin
            set_sw(10'(k << 7), 6);
            `CHK("ramp_set", 2'(k), ramp_set)
        end
        set_sw(10'h200, 6); `CHK("motor_set", 2'h1, motor_set)
        set_sw(10'h000, 6); `CHK("motor_set", 2'h0, motor_set)
        apb(1'b1, 12'h0A4, 32'h0000002A);
        set_sw(10'h200, 6); `CHK("motor_set bit1", 2'h2, motor_set)
    endtask : test_ramp_motor
    task automatic test_debounce();
        apb(1'b1, OFS_DEBOUNCE, 32'h2);
        @(posedge pclk); chatter <= 1'b1;
        repeat (12) @(posedge pclk);
        chatter <= 1'b0;
        set_sw(10'h008, 3); `CHK("step_index short", 4'h0, step_index)
        set_sw(10'h000, 12); `CHK("step_index bounce", 4'h0, step_index)
        set_sw(10'h008, 14); `CHK("step_index held", 4'h1, step_index)
    endtask : test_debounce
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_two_wire();
        test_three_wire_one();
        test_three_wire_two();
        test_steps();
        test_ramp_motor();
        test_debounce();
        final_report();
    end
endmodule : trcd_top_test
